// File: dsp_pkg.sv
// shared types and constants of the disk drive control signal port
// Overview of operation
// - strobe selects while direction-out active, polls attention while inactive
// - at most one device selected; selection changes only on strobe edge or when port enable goes inactive
// - on strobe edge become selected if own bus line active, else deselected
// - strobe edge with all bus lines inactive deselects every device
// - during attention poll drive own attention condition onto own bus line
// - selected device drives parameter or status byte on inbound request
// - newly selected device asserts acknowledge to confirm selection
// - acknowledge answers each command and parameter request in handshake
// - busy goes active before acknowledge edge of a time-dependent command
// - end of internal busy sets the attention condition
// - command request during busy gets no acknowledge until busy ends
// - wired-OR attention driven when condition set and reporting enabled
// - attention cleared only by clear-attention or clear-fault command
// - selected ready device emits one index pulse per revolution
// - sector zero starts at index; sector pulse suppressed at index
// - remainder of track goes into the last sector, never a short one
// - no recording under write gate unless write enable was set before
// - read data sent on read clock under read gate, static otherwise
// - returned clock is read clock under read gate, else reference, no glitch
// - bus and control lines are active low
// - bit 6 of first byte sets parameter direction; mismatch sets bus error
package dsp_pkg;

	localparam int CLK_MHZ = 50;

	// one revolution and the seek time, in microseconds
	localparam int REV_US   = 16667;
	localparam int REV_CYC  = REV_US * CLK_MHZ;
	localparam int SEEK_US  = 5000;
	localparam int SEEK_CYC = SEEK_US * CLK_MHZ;

	// index and sector pulse width, least time, rounded up
	localparam int PULSE_NS  = 160;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;

	localparam int SECTORS = 32;

	// half periods of the returned clock in system clocks
	localparam logic [7:0] REF_HALF = 8'h02;
	localparam logic [7:0] RD_HALF  = 8'h03;

	localparam int DIR_BIT = 6;

	localparam logic [7:0] CMD_CLR_FAULT = 8'h01;
	localparam logic [7:0] CMD_CLR_ATTN  = 8'h02;
	localparam logic [7:0] CMD_SEEK      = 8'h03;
	localparam logic [7:0] CMD_REZERO    = 8'h04;
	localparam logic [7:0] CMD_SET_ATTN  = 8'h11;
	localparam logic [7:0] CMD_RPT_TEST  = 8'h2f;
	localparam logic [7:0] CMD_ATTN_CTL  = 8'h40;
	localparam logic [7:0] CMD_WR_CTL    = 8'h41;
	localparam logic [7:0] CMD_LOAD_TEST = 8'h6f;

	// general status byte bit positions
	localparam int GS_BUSY    = 0;
	localparam int GS_BUS_ERR = 1;
	localparam int GS_FAULT   = 2;
	localparam int GS_WR_EN   = 3;
	localparam int GS_ATTN    = 7;

	localparam logic ATTN_EN_RST = 1'b1;

	typedef enum logic [4:0] {
		HS_IDLE     = 5'b00001,
		HS_CMD_ACK  = 5'b00010,
		HS_WAIT_PAR = 5'b00100,
		HS_PAR_SET  = 5'b01000,
		HS_PAR_ACK  = 5'b10000
	} dsp_hs_t;

	// host pins after inversion: 1 means active
	typedef struct packed {
		logic [7:0] cbus;
		logic       strobe;
		logic       dir;
		logic       cmd;
		logic       par;
		logic       rgate;
		logic       pen;
	} dsp_pins_t;

	typedef struct packed {
		dsp_pins_t  s1;
		dsp_pins_t  s2;
		dsp_pins_t  s3;
		dsp_pins_t  pf;
		dsp_pins_t  pv;
		dsp_hs_t    state;
		logic       sel;
		logic       attn;
		logic       attn_en;
		logic       wr_en;
		logic       wr_arm;
		logic       fault;
		logic       bus_err;
		logic       busy;
		logic       drv;
		logic [31:0] busy_cnt;
		logic [31:0] rev_cnt;
		logic [31:0] sec_cnt;
		logic [15:0] sec_idx;
		logic [7:0] cmd;
		logic [7:0] test;
		logic [7:0] div_cnt;
		logic       rd_mode;
		logic       rclk;
		logic       rdata;
		logic [7:0] cbus_do;
		logic [7:0] cbus_oe;
		logic       ack_n;
		logic       busy_n;
		logic       attn_oe;
		logic       index_n;
		logic       sector_n;
		logic [2:0] wg;
		logic       wgf;
		logic       rec_en;
	} dsp_main_t;

	typedef struct packed {
		logic r1;
		logic r2;
		logic a1;
		logic a2;
		logic g1;
		logic g2;
		logic g3;
		logic gf;
		logic rec_en;
		logic rec_data;
	} dsp_wr_t;

endpackage

// File: dsp_port.sv
// device end of the disk drive control signal port
`timescale 1ns/1ps
module dsp_port
	import dsp_pkg::*;
#(
	parameter int UNIT        = 0,
	parameter int REV_CYCLES  = REV_CYC,
	parameter int SEEK_CYCLES = SEEK_CYC,
	parameter int SECT_CNT    = SECTORS
)(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       wclk,
	input  wire logic [7:0] cbus_n_i,
	output logic      [7:0] cbus_n_o,
	output logic      [7:0] cbus_oe,
	input  wire logic       strobe_n,
	input  wire logic       cmd_req_n,
	input  wire logic       par_req_n,
	input  wire logic       dir_out_n,
	input  wire logic       port_en_n,
	input  wire logic       read_gate_n,
	input  wire logic       write_gate_n,
	input  wire logic       wr_data,
	input  wire logic       drive_ready,
	input  wire logic       fault_in,
	input  wire logic       med_bit,
	output logic            ack_n,
	output logic            busy_n,
	output logic            attn_n_o,
	output logic            attn_oe,
	output logic            index_n,
	output logic            sector_n,
	output logic            rd_data,
	output logic            rd_clk,
	output logic            rec_en,
	output logic            rec_data,
	output logic            selected,
	output logic            attn_cond
);

	localparam int SECT_LEN = REV_CYCLES / SECT_CNT;

	dsp_main_t st;
	dsp_main_t nxt;
	dsp_wr_t   wst;
	dsp_wr_t   nxtw;

	dsp_pins_t  p;
	logic       stb_rise;
	logic       pen_rise;
	logic       poll;
	logic       sel_ack;
	logic       attn_set;
	logic       attn_clr;
	logic       fault_clr;
	logic       dir_err;
	logic [7:0] rsp;
	logic [7:0] half;

	// a change counts once the second and third stages agree
	function automatic logic [13:0] agree(input logic [13:0] held,
		input logic [13:0] b, input logic [13:0] c);
		agree = (b & c) | (held & (b | c));
	endfunction

	function automatic logic is_timed(input logic [7:0] code);
		is_timed = (code == CMD_SEEK) || (code == CMD_REZERO);
	endfunction

	function automatic logic [7:0] gen_status(input dsp_main_t s);
		gen_status = 8'h00;
		gen_status[GS_BUSY]    = s.busy;
		gen_status[GS_BUS_ERR] = s.bus_err;
		gen_status[GS_FAULT]   = s.fault;
		gen_status[GS_WR_EN]   = s.wr_en;
		gen_status[GS_ATTN]    = s.attn;
	endfunction

	always_comb begin
		nxt       = st;
		attn_set  = 1'b0;
		attn_clr  = 1'b0;
		fault_clr = 1'b0;
		dir_err   = 1'b0;
		rsp       = gen_status(st);
		half      = st.rd_mode ? RD_HALF : REF_HALF;

		// host lines are active low; inverted ahead of the synchroniser
		nxt.s1.cbus   = ~cbus_n_i;
		nxt.s1.strobe = ~strobe_n;
		nxt.s1.dir    = ~dir_out_n;
		nxt.s1.cmd    = ~cmd_req_n;
		nxt.s1.par    = ~par_req_n;
		nxt.s1.rgate  = ~read_gate_n;
		nxt.s1.pen    = ~port_en_n;
		nxt.s2 = st.s1;
		nxt.s3 = st.s2;
		nxt.pf = dsp_pins_t'(agree(st.pf, st.s2, st.s3));
		nxt.pv = st.pf;

		p        = st.pf;
		stb_rise = p.strobe & ~st.pv.strobe;
		pen_rise = p.pen & ~st.pv.pen;
		poll     = p.strobe & ~p.dir & p.pen;
		sel_ack  = p.strobe & p.dir & st.sel;

		// the edge of the strobe moves selection; port enable inactive clears it below
		if (stb_rise && p.dir && p.pen) begin
			nxt.sel = p.cbus[UNIT];
		end

		if (pen_rise) begin
			attn_set = 1'b1;
		end

		case (st.state)
			HS_IDLE: begin
				// a request during busy waits here with no acknowledge
				if (st.sel && p.cmd && p.dir && !p.strobe && !st.busy) begin
					nxt.cmd   = p.cbus;
					nxt.state = HS_CMD_ACK;
				end
			end
			HS_CMD_ACK: begin
				if (!p.cmd) begin
					nxt.state = HS_WAIT_PAR;
				end
			end
			HS_WAIT_PAR: begin
				if (p.par) begin
					dir_err = p.dir != st.cmd[DIR_BIT];
					if (dir_err) begin
						nxt.bus_err = 1'b1;
						attn_set    = 1'b1;
					end else if (p.dir) begin
						// byte is valid while the request stands
						case (st.cmd)
							CMD_ATTN_CTL:  nxt.attn_en = ~p.cbus[7];
							CMD_WR_CTL:    nxt.wr_en   = p.cbus[7];
							CMD_LOAD_TEST: nxt.test    = p.cbus;
							default:       nxt.test    = st.test;
						endcase
					end else begin
						case (st.cmd)
							CMD_CLR_ATTN:  attn_clr  = 1'b1;
							CMD_CLR_FAULT: fault_clr = 1'b1;
							CMD_SET_ATTN:  attn_set  = 1'b1;
							CMD_RPT_TEST:  rsp       = st.test;
							default:       rsp       = gen_status(st);
						endcase
						// busy rises a cycle ahead of the acknowledge
						if (is_timed(st.cmd)) begin
							nxt.busy     = 1'b1;
							nxt.busy_cnt = 32'(SEEK_CYCLES);
						end
					end
					nxt.drv     = ~p.dir;
					nxt.cbus_do = ~rsp;
					nxt.state   = HS_PAR_SET;
				end
			end
			HS_PAR_SET: begin
				nxt.state = HS_PAR_ACK;
			end
			HS_PAR_ACK: begin
				if (!p.par) begin
					nxt.drv   = 1'b0;
					nxt.state = HS_IDLE;
				end
			end
			default: begin
				nxt.state = HS_IDLE;
			end
		endcase

		if (!p.pen) begin
			nxt.sel   = 1'b0;
			nxt.wr_en = 1'b0;
			nxt.drv   = 1'b0;
			nxt.state = HS_IDLE;
		end else if (!nxt.sel && st.state != HS_IDLE) begin
			nxt.drv   = 1'b0;
			nxt.state = HS_IDLE;
		end

		if (st.busy) begin
			nxt.busy_cnt = st.busy_cnt - 32'h1;
			if (st.busy_cnt <= 32'h1) begin
				nxt.busy = 1'b0;
				attn_set = 1'b1;
			end
		end

		// a fault still present stays set, and so does its attention
		if (fault_in && !st.fault) begin
			attn_set = 1'b1;
		end
		if (fault_clr) begin
			nxt.bus_err = 1'b0;
			attn_clr    = ~fault_in;
		end
		nxt.fault = fault_in | (st.fault & ~fault_clr);
		nxt.attn  = attn_set | (st.attn & ~attn_clr);

		nxt.wr_arm = nxt.sel & nxt.wr_en & p.pen;

		// the write clock may halt as soon as the gate drops, so the
		// record enable is ended from this clock, not from the write clock
		nxt.wg     = {st.wg[1:0], ~write_gate_n};
		nxt.wgf    = (st.wg[1] & st.wg[2]) | (st.wgf & (st.wg[1] | st.wg[2]));
		nxt.rec_en = st.wgf & st.wr_arm;

		if (nxt.drv) begin
			nxt.cbus_oe = 8'hff;
		end else if (poll) begin
			nxt.cbus_oe       = 8'h00;
			nxt.cbus_oe[UNIT] = st.attn;
			nxt.cbus_do       = 8'h00;
		end else begin
			nxt.cbus_oe = 8'h00;
			nxt.cbus_do = 8'h00;
		end

		nxt.ack_n = ~(nxt.state == HS_CMD_ACK || nxt.state == HS_PAR_ACK
			|| sel_ack);
		nxt.busy_n  = ~nxt.busy;
		// wired-OR line: pulled low regardless of selection
		nxt.attn_oe = nxt.attn & nxt.attn_en & p.pen;

		// the last sector takes whatever the division leaves
		if (st.rev_cnt >= 32'(REV_CYCLES - 1)) begin
			nxt.rev_cnt = 32'h0;
			nxt.sec_cnt = 32'h0;
			nxt.sec_idx = 16'h0;
		end else begin
			nxt.rev_cnt = st.rev_cnt + 32'h1;
			if (st.sec_idx < 16'(SECT_CNT - 1)
				&& st.sec_cnt >= 32'(SECT_LEN - 1)) begin
				nxt.sec_cnt = 32'h0;
				nxt.sec_idx = st.sec_idx + 16'h1;
			end else begin
				nxt.sec_cnt = st.sec_cnt + 32'h1;
			end
		end
		// a mark starts only when ready and selected, then runs its full
		// width, so selection or ready changes never leave a runt pulse
		nxt.index_n = ~(nxt.rev_cnt == 32'h0 ? drive_ready && st.sel
			: !st.index_n && nxt.rev_cnt < 32'(PULSE_CYC));
		nxt.sector_n = ~(nxt.sec_idx != 16'h0
			&& (nxt.sec_cnt == 32'h0 ? drive_ready && st.sel
			: !st.sector_n && nxt.sec_cnt < 32'(PULSE_CYC)));

		// source switches only after a full high phase, so no runt pulse
		if (st.div_cnt >= half - 8'h1) begin
			nxt.div_cnt = 8'h0;
			nxt.rclk    = ~st.rclk;
			if (st.rclk) begin
				nxt.rd_mode = p.rgate & st.sel;
				if (st.rd_mode) begin
					nxt.rdata = med_bit;
				end
			end
		end else begin
			nxt.div_cnt = st.div_cnt + 8'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st          <= '0;
			st.state    <= HS_IDLE;
			st.attn_en  <= ATTN_EN_RST;
			st.ack_n    <= 1'b1;
			st.busy_n   <= 1'b1;
			st.index_n  <= 1'b1;
			st.sector_n <= 1'b1;
		end else begin
			st <= nxt;
		end
	end

	// write side runs on the host's write clock
	always_comb begin
		nxtw    = wst;
		nxtw.r1 = rst_n;
		nxtw.r2 = wst.r1;
		nxtw.a1 = st.wr_arm;
		nxtw.a2 = wst.a1;
		nxtw.g1 = ~write_gate_n;
		nxtw.g2 = wst.g1;
		nxtw.g3 = wst.g2;
		nxtw.gf = (wst.g2 & wst.g3) | (wst.gf & (wst.g2 | wst.g3));
		nxtw.rec_en = wst.gf & wst.a2;
		// data is already phased to this clock by the host
		if (wst.rec_en) begin
			nxtw.rec_data = wr_data;
		end
	end

	always_ff @(posedge wclk) begin
		if (!wst.r2) begin
			wst    <= '0;
			wst.r1 <= nxtw.r1;
			wst.r2 <= nxtw.r2;
		end else begin
			wst <= nxtw;
		end
	end

	assign cbus_n_o  = st.cbus_do;
	assign cbus_oe   = st.cbus_oe;
	assign ack_n     = st.ack_n;
	assign busy_n    = st.busy_n;
	assign attn_n_o  = 1'b0;
	assign attn_oe   = st.attn_oe;
	assign index_n   = st.index_n;
	assign sector_n  = st.sector_n;
	assign rd_data   = st.rdata;
	assign rd_clk    = st.rclk;
	assign rec_en    = st.rec_en;
	assign rec_data  = wst.rec_data;
	assign selected  = st.sel;
	assign attn_cond = st.attn;

endmodule

// File: dsp_port_props.sv
// assertions on the ports of the disk drive control signal port
`timescale 1ns/1ps
module dsp_port_props
	import dsp_pkg::*;
#(
	parameter int UNIT = 0
)(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic [7:0] cbus_n_o,
	input wire logic [7:0] cbus_oe,
	input wire logic       strobe_n,
	input wire logic       cmd_req_n,
	input wire logic       par_req_n,
	input wire logic       ack_n,
	input wire logic       busy_n,
	input wire logic       attn_oe,
	input wire logic       index_n,
	input wire logic       sector_n,
	input wire logic       rd_data,
	input wire logic       rd_clk,
	input wire logic       selected,
	input wire logic       attn_cond
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_sel_ack: assert property ($rose(selected) |-> ##[0:2] !ack_n)
		else $error("selection not acknowledged");
	a_sel_strobe: assert property ($changed(selected) |-> !strobe_n)
		else $error("selection changed without strobe");
	a_busy_hold: assert property (
		$fell(ack_n) && !cmd_req_n && par_req_n |-> $past(busy_n))
		else $error("command acknowledged while busy");
	a_busy_attn: assert property ($rose(busy_n) |-> ##[0:2] attn_cond)
		else $error("busy end did not raise attention");
	a_attn_pin: assert property (attn_oe |-> attn_cond || $past(attn_cond))
		else $error("attention driven without condition");
	a_attn_clr: assert property (
		$fell(attn_cond) |-> !cmd_req_n || !par_req_n)
		else $error("attention cleared outside a command");
	a_poll_line: assert property (
		cbus_oe[UNIT] && !strobe_n |-> attn_cond && !cbus_n_o[UNIT])
		else $error("poll line does not show attention");
	a_idx_width: assert property (
		$fell(index_n) |-> !index_n [*8] ##1 index_n)
		else $error("index pulse width wrong");
	a_sec_omit: assert property (!index_n |-> sector_n)
		else $error("sector pulse during index");
	a_rd_sync: assert property ($changed(rd_data) |-> $fell(rd_clk))
		else $error("read data moved off the clock edge");
	a_rclk_half: assert property ($changed(rd_clk) |=> $stable(rd_clk))
		else $error("returned clock glitch");
	c_sel: cover property ($rose(selected));
	c_busy: cover property ($rose(busy_n));
	c_index: cover property ($fell(index_n));
endmodule

bind dsp_port dsp_port_props #(.UNIT(UNIT)) dsp_port_props_i (
	.clock, .rst_n, .cbus_n_o, .cbus_oe, .strobe_n, .cmd_req_n,
	.par_req_n, .ack_n, .busy_n, .attn_oe, .index_n, .sector_n,
	.rd_data, .rd_clk, .selected, .attn_cond);

// File: dsp_host.sv
// host controller model driving the control bus
`timescale 1ns/1ps
module dsp_host
	import dsp_pkg::*;
(
	input  wire logic       clock,
	input  wire logic [7:0] cbus_n_o,
	input  wire logic [7:0] cbus_oe,
	input  wire logic       ack_n,
	output logic      [7:0] cbus_n_i,
	output logic            strobe_n,
	output logic            cmd_req_n,
	output logic            par_req_n,
	output logic            dir_out_n
);
	logic [7:0] drv_n;
	logic       drv_en;
	logic       tmo;
	initial begin
		drv_n = 8'hff;
		drv_en = 1'b0;
		tmo = 1'b0;
		strobe_n = 1'b1;
		cmd_req_n = 1'b1;
		par_req_n = 1'b1;
		dir_out_n = 1'b1;
	end
	// released lines float to the pull-up, the inactive level
	always_comb
		for (int i = 0; i < 8; i++)
			cbus_n_i[i] = cbus_oe[i] ? cbus_n_o[i] : (drv_en ? drv_n[i] : 1'b1);
	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		while (ack_n !== lvl && n < 400) begin
			@(negedge clock);
			n++;
		end
		if (n == 400)
			tmo = 1'b1;
	endtask
	task automatic strobe(input logic out, input logic [7:0] lines_n);
		@(negedge clock);
		dir_out_n = !out;
		drv_n = lines_n;
		drv_en = out;
		strobe_n = 1'b0;
		repeat (8) @(negedge clock);
	endtask
	task automatic free();
		strobe_n = 1'b1;
		drv_en = 1'b0;
		dir_out_n = 1'b1;
		repeat (10) @(negedge clock);
	endtask
	task automatic xfer(input logic [7:0] c, input logic out,
			input logic [7:0] p, output logic [7:0] rd);
		@(negedge clock);
		dir_out_n = 1'b0;
		drv_n = ~c;
		drv_en = 1'b1;
		cmd_req_n = 1'b0;
		wait_ack(1'b0);
		cmd_req_n = 1'b1;
		drv_en = 1'b0;
		wait_ack(1'b1);
		dir_out_n = !out;
		drv_n = ~p;
		drv_en = out;
		par_req_n = 1'b0;
		wait_ack(1'b0);
		rd = ~cbus_n_i;
		par_req_n = 1'b1;
		drv_en = 1'b0;
		dir_out_n = 1'b1;
		wait_ack(1'b1);
	endtask
endmodule

// File: dsp_port_tb_top.sv
// self-checking bench for the disk drive control signal port
`timescale 1ns/1ps
module dsp_port_tb_top
	import dsp_pkg::*;
;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       wclk = 1'b0;
	logic       wrun = 1'b1;
	logic       read_gate_n = 1'b1;
	logic       write_gate_n = 1'b1;
	logic       wr_data = 1'b0;
	logic       med_bit = 1'b0;
	logic       drive_ready = 1'b1;
	logic       fault_in = 1'b0;
	logic [7:0] cbus_n_i, cbus_n_o, cbus_oe, rd;
	logic       strobe_n, cmd_req_n, par_req_n, dir_out_n, ack_n, busy_n;
	logic       attn_oe, index_n, sector_n, rd_data, rd_clk, rec_en;
	logic       rec_data, selected, attn_cond, attn_n_o;
	int         err_count = 0;
	int         comparisons = 0;
	int         a, b;
	initial forever #10 clock = !clock;
	// write clock runs through reset and within frames, with its own phase
	initial begin
		#7;
		forever begin
			#40;
			wclk = wrun ? !wclk : 1'b0;
		end
	end
	always begin
		repeat (7) @(negedge clock);
		med_bit = !med_bit;
	end
	dsp_port #(.UNIT(0), .REV_CYCLES(403), .SEEK_CYCLES(50), .SECT_CNT(5))
	dsp_port_i (
		.clock, .rst_n, .wclk, .cbus_n_i, .cbus_n_o, .cbus_oe, .strobe_n,
		.cmd_req_n, .par_req_n, .dir_out_n, .port_en_n(1'b0),
		.read_gate_n, .write_gate_n, .wr_data, .drive_ready,
		.fault_in, .med_bit, .ack_n, .busy_n, .attn_n_o,
		.attn_oe, .index_n, .sector_n, .rd_data, .rd_clk, .rec_en,
		.rec_data, .selected, .attn_cond);
	dsp_host dsp_host_i (.clock, .cbus_n_o, .cbus_oe, .ack_n, .cbus_n_i,
		.strobe_n, .cmd_req_n, .par_req_n, .dir_out_n);
	task automatic results();
		$display("counts: %0d compares, %0d bad", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xf(input logic [7:0] c, input logic o, input logic [7:0] p);
		dsp_host_i.xfer(c, o, p, rd);
		if (dsp_host_i.tmo) begin
			err_count++;
			results();
		end
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_n !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		if (n == 300) begin
			err_count++;
			results();
		end
		repeat (4) @(negedge clock);
	endtask
	task automatic marks();
		int ni, ns, ts, gap;
		logic pi, ps;
		ni = 0;
		ns = 0;
		ts = 0;
		gap = 0;
		pi = index_n;
		ps = sector_n;
		for (int i = 0; i < 806; i++) begin
			@(negedge clock);
			if (!index_n && pi) begin
				ni++;
				gap = i - ts;
			end
			if (!sector_n && ps) begin
				ns++;
				ts = i;
			end
			pi = index_n;
			ps = sector_n;
		end
		chk("index count", ni[7:0], 8'h02);
		chk("sector count", ns[7:0], 8'h08);
		chk("last sector long", gap >= 80, 8'h01);
	endtask
	task automatic win(output int nc, output int nd);
		logic pc, pd;
		nc = 0;
		nd = 0;
		pc = rd_clk;
		pd = rd_data;
		repeat (120) begin
			@(negedge clock);
			nc += int'(rd_clk && !pc);
			nd += int'(rd_data !== pd);
			pc = rd_clk;
			pd = rd_data;
		end
	endtask
	// gate and data change together; data stays static between frames
	task automatic wframe(input logic d, input logic on);
		wrun = 1'b1;
		repeat (2) @(negedge wclk);
		write_gate_n = 1'b0;
		wr_data = d;
		repeat (6) @(negedge wclk);
		chk("record enable", rec_en, on);
		if (on)
			chk("record bit", rec_data, d);
		write_gate_n = 1'b1;
		repeat (2) @(negedge wclk);
		wrun = 1'b0;
		repeat (8) @(negedge clock);
		chk("record stops", rec_en, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		wrun = 1'b0;
		repeat (4) @(negedge clock);
		chk("selected", selected, 8'h00);
		dsp_host_i.strobe(1'b1, 8'hfe);
		chk("selected", selected, 8'h01);
		chk("select ack", ack_n, 8'h00);
		dsp_host_i.free();
		xf(CMD_CLR_ATTN, 1'b0, 8'h00);
		chk("attention reset clear", attn_cond, 8'h00);
		xf(CMD_SEEK, 1'b0, 8'h00);
		chk("busy", busy_n, 8'h00);
		wait_idle();
		chk("attention", attn_cond, 8'h01);
		chk("attention pin", attn_oe, 8'h01);
		chk("attention wire", attn_n_o, 8'h00);
		dsp_host_i.strobe(1'b0, 8'hff);
		chk("poll enable", cbus_oe[0], 8'h01);
		chk("poll line", cbus_n_i[0], 8'h00);
		chk("poll keeps select", selected, 8'h01);
		dsp_host_i.free();
		$display("select and poll done");
		xf(CMD_SEEK, 1'b0, 8'h00);
		xf(CMD_CLR_ATTN, 1'b0, 8'h00);
		chk("held until idle", rd[GS_BUSY], 8'h00);
		chk("attention clear", attn_cond, 8'h00);
		xf(CMD_ATTN_CTL, 1'b1, 8'h80);
		xf(CMD_SET_ATTN, 1'b0, 8'h00);
		chk("attention disabled", attn_oe, 8'h00);
		xf(CMD_ATTN_CTL, 1'b1, 8'h00);
		chk("attention enabled", attn_oe, 8'h01);
		xf(CMD_LOAD_TEST, 1'b1, 8'ha5);
		xf(CMD_RPT_TEST, 1'b0, 8'h00);
		chk("echo byte", rd, 8'ha5);
		xf(CMD_RPT_TEST, 1'b1, 8'h00);
		xf(CMD_SET_ATTN, 1'b0, 8'h00);
		chk("bus error", rd[GS_BUS_ERR], 8'h01);
		xf(CMD_CLR_FAULT, 1'b0, 8'h00);
		chk("fault clear", attn_cond, 8'h00);
		fault_in = 1'b1;
		xf(CMD_CLR_FAULT, 1'b0, 8'h00);
		chk("fault status", rd[GS_FAULT], 8'h01);
		chk("fault keeps attention", attn_cond, 8'h01);
		xf(CMD_CLR_ATTN, 1'b0, 8'h00);
		chk("attention forced clear", attn_cond, 8'h00);
		fault_in = 1'b0;
		xf(CMD_REZERO, 1'b0, 8'h00);
		chk("rezero busy", busy_n, 8'h00);
		wait_idle();
		$display("command test done");
		marks();
		drive_ready = 1'b0;
		repeat (10) @(negedge clock);
		a = 0;
		repeat (410) begin
			@(negedge clock);
			a += int'(!index_n || !sector_n);
		end
		chk("marks while not ready", a[7:0], 8'h00);
		drive_ready = 1'b1;
		win(a, b);
		chk("reference clock", a >= 29 && a <= 31, 8'h01);
		chk("read data idle", b[7:0], 8'h00);
		read_gate_n = 1'b0;
		repeat (10) @(negedge clock);
		win(a, b);
		chk("read clock", a >= 19 && a <= 21, 8'h01);
		chk("read data moves", b > 0, 8'h01);
		read_gate_n = 1'b1;
		wframe(1'b1, 1'b0);
		xf(CMD_WR_CTL, 1'b1, 8'h80);
		wframe(1'b1, 1'b1);
		$display("data path test done");
		dsp_host_i.strobe(1'b1, 8'hfd);
		chk("other unit", selected, 8'h00);
		dsp_host_i.free();
		dsp_host_i.strobe(1'b1, 8'hfe);
		dsp_host_i.free();
		dsp_host_i.strobe(1'b1, 8'hff);
		chk("all deselected", selected, 8'h00);
		dsp_host_i.free();
		results();
	end
endmodule
